//--- hdl/limit_seq_bank.sv
// limit, sequence-mask and output converter control bank with the
// battery-two and temperature limit checks and a measurement sequencer
// assumes write/read strobes come from the serial port framing, one clock
//
// What this block does
// R1 - battery-two upper limit, 12 bit, write 1000, read 01000, resets zero
// R2 - battery-two lower limit, write 1001, read 01001, resets zero
// R3 - temperature lower limit, write 1010, read 01010
// R4 - temperature upper limit, write 1011, read 01011
// R5 - slave sequence mask, write 1100, read 01100, zero reset
// R6 - slave mask: bit1 pressure one, 9 pressure two, 10 horizontal, 11 vertical
// R7 - slave mask: bit2 differential temperature, bit3 single-ended temperature
// R8 - slave mask: bit4 battery two, 5 battery one, 6..8 aux three..one
// R9 - master sequence mask, write 1101, read 01101, zero reset
// R10 - master mask: bit1 pressure one, 9 pressure two, 10 horiz, 11 vert
// R11 - master mask: bit2 differential, bit3 single-ended temperature
// R12 - master mask: bit4 battery two, 5 battery one, 6..8 aux three..one
// R13 - mask bit0 and control bit1 do nothing but store and read back
// R14 - converter control at write 1110, read 01110, reset 0x008, code bits 4..11
// R15 - control bit0 picks full supply span when set, half supply when clear
// R16 - control bit2 picks current output when set, voltage when clear
// R17 - control bit3 powers the converter off; off after reset
// R18 - battery-two result below lower sets low flag, above upper sets high
// R19 - temperature limit alert reaches alert output only while enabled
// R20 - a write replaces all twelve bits; a later read returns them unchanged
// R21 - sequences run selected measurements in fixed order; empty mask does none
`timescale 1ns/1ps
`include "limit_seq_defines.svh"

module limit_seq_bank (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_addr_i,
  input wire logic [11:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [4:0] rd_addr_i,
  output logic [11:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic seq_start_i,
  input wire logic seq_master_i,
  input wire logic meas_done_i,
  output logic meas_req_o,
  output logic [3:0] meas_select_o,
  output logic seq_busy_o,
  output logic seq_done_o,
  input wire logic result_valid_i,
  input wire logic [3:0] result_select_i,
  input wire logic [11:0] result_data_i,
  input wire logic alert_clear_i,
  input wire logic battery_alert_enable_i,
  input wire logic temperature_alert_enable_i,
  output logic battery_two_low_flag_o,
  output logic battery_two_high_flag_o,
  output logic temperature_low_flag_o,
  output logic temperature_high_flag_o,
  output logic alert_o,
  output logic [7:0] output_code_o,
  output logic full_span_o,
  output logic current_mode_o,
  output logic converter_power_off_o
);
  localparam int WORD_BITS = `LSD_WORD_BITS;
  if (WORD_BITS != 12)
  begin : g_bad_width
    $error("bank logic assumes 12-bit words");
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // ===================================================================
  // address decode
  function automatic logic in_bank(input logic [4:0] addr);
    in_bank = addr >= `LSD_RA_BATTERY_TWO_UPPER &&
      addr <= `LSD_RA_OUTPUT_CONTROL;
  endfunction

  reg_store_if store_bus ();

  wire logic wr_hit = wr_en_i && in_bank({1'b0, wr_addr_i}); // R20
  wire logic rd_hit = in_bank(rd_addr_i);

  assign store_bus.wr_en = wr_hit; // R20
  assign store_bus.wr_idx = wr_addr_i[2:0]; // R1 R2 R3 R4 R5 R9 R14
  assign store_bus.wr_data = wr_data_i; // R13
  assign store_bus.rd_en = rd_en_i;
  assign store_bus.rd_hit = rd_hit;
  assign store_bus.rd_idx = rd_addr_i[2:0];

  reg_store #(
    .DEPTH(`LSD_NUM_WORDS),
    .RESET_IMAGE({`LSD_RST_OUTPUT_CONTROL, `LSD_RST_MASK, `LSD_RST_MASK,
      `LSD_RST_LIMIT, `LSD_RST_LIMIT, `LSD_RST_LIMIT, `LSD_RST_LIMIT})
  ) u_store (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .bus(store_bus)
  );

  assign rd_data_o = store_bus.rd_data; // R20

  logic rd_valid_reg;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      rd_valid_reg <= 1'b0;
    else
      rd_valid_reg <= rd_en_i;
  end
  assign rd_valid_o = rd_valid_reg;

  // ===================================================================
  // named words and converter control fields
  wire limit_seq_pkg::word_t bat_upper =
    store_bus.words[`LSD_IDX_BATTERY_TWO_UPPER];
  wire limit_seq_pkg::word_t bat_lower =
    store_bus.words[`LSD_IDX_BATTERY_TWO_LOWER];
  wire limit_seq_pkg::word_t temp_lower =
    store_bus.words[`LSD_IDX_TEMPERATURE_LOWER];
  wire limit_seq_pkg::word_t temp_upper =
    store_bus.words[`LSD_IDX_TEMPERATURE_UPPER];
  wire limit_seq_pkg::word_t slave_mask =
    store_bus.words[`LSD_IDX_SLAVE_MASK];
  wire limit_seq_pkg::word_t master_mask =
    store_bus.words[`LSD_IDX_MASTER_MASK];
  wire limit_seq_pkg::word_t control =
    store_bus.words[`LSD_IDX_OUTPUT_CONTROL];

  // these come straight off the stored control word flops
  assign output_code_o =
    control[`LSD_CTL_CODE_MSB:`LSD_CTL_CODE_LSB]; // R14
  assign full_span_o = control[`LSD_CTL_FULL_SPAN]; // R15
  assign current_mode_o = control[`LSD_CTL_CURRENT_MODE]; // R16
  assign converter_power_off_o = control[`LSD_CTL_POWER_OFF]; // R17

  // ===================================================================
  // limit checks; a new alert wins over a clear in the same cycle
  wire logic bat_result = result_valid_i &&
    result_select_i == 4'(`LSD_SEL_BATTERY_TWO);
  wire logic temp_result = result_valid_i &&
    result_select_i == 4'(`LSD_SEL_SINGLE_TEMP);
  wire logic bat_low_set = bat_result && result_data_i < bat_lower; // R18
  wire logic bat_high_set = bat_result && result_data_i > bat_upper; // R18
  wire logic temp_low_set = temp_result && result_data_i < temp_lower;
  wire logic temp_high_set = temp_result && result_data_i > temp_upper;

  logic [3:0] flags_reg;
  wire logic [3:0] flags_set =
    {temp_high_set, temp_low_set, bat_high_set, bat_low_set};
  wire logic [3:0] flags_next =
    (flags_reg & {4{~alert_clear_i}}) | flags_set; // R18
  // gating uses the held flags, so alert trails its flag by one cycle
  wire logic alert_next =
    (battery_alert_enable_i && |flags_reg[1:0]) ||
    (temperature_alert_enable_i && |flags_reg[3:2]); // R19

  logic alert_reg;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      flags_reg <= 4'h0;
      alert_reg <= 1'b0;
    end
    else
    begin
      flags_reg <= flags_next;
      alert_reg <= alert_next;
    end
  end
  assign battery_two_low_flag_o = flags_reg[0];
  assign battery_two_high_flag_o = flags_reg[1];
  assign temperature_low_flag_o = flags_reg[2];
  assign temperature_high_flag_o = flags_reg[3];
  assign alert_o = alert_reg;

  // ===================================================================
  // sequencer: lowest set mask bit first, bit 0 never runs
  function automatic limit_seq_pkg::select_t first_set(
    input limit_seq_pkg::word_t mask);
    first_set = 4'h0;
    for (int b = WORD_BITS - 1; b > `LSD_SEL_UNUSED; b--)
      if (mask[b])
        first_set = 4'(b);
  endfunction

  // bit 0 carries no measurement in either mask
  wire limit_seq_pkg::word_t chosen_mask =
    (seq_master_i ? master_mask : slave_mask) & 12'hFFE; // R5 R9 R13
  limit_seq_pkg::seq_state_e state_reg;
  limit_seq_pkg::word_t pending_reg;
  logic meas_req_reg;
  logic [3:0] meas_select_reg;
  logic done_reg;

  wire logic start_ok = seq_start_i && state_reg == limit_seq_pkg::SEQ_IDLE;
  wire limit_seq_pkg::select_t next_select =
    first_set(pending_reg); // R6 R7 R8 R10 R11 R12 R21
  wire logic last_done = state_reg == limit_seq_pkg::SEQ_WAIT &&
    meas_done_i && pending_reg == 12'h000;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= limit_seq_pkg::SEQ_IDLE;
      pending_reg <= 12'h000;
      meas_req_reg <= 1'b0;
      meas_select_reg <= 4'h0;
      done_reg <= 1'b0;
    end
    else
    begin
      meas_req_reg <= 1'b0;
      done_reg <= last_done || (start_ok && chosen_mask == 12'h000); // R21
      case (state_reg)
        limit_seq_pkg::SEQ_IDLE:
          if (start_ok && chosen_mask != 12'h000)
          begin
            pending_reg <= chosen_mask;
            state_reg <= limit_seq_pkg::SEQ_ISSUE;
          end
        limit_seq_pkg::SEQ_ISSUE:
        begin
          meas_req_reg <= 1'b1; // R21
          meas_select_reg <= next_select;
          pending_reg[next_select] <= 1'b0;
          state_reg <= limit_seq_pkg::SEQ_WAIT;
        end
        limit_seq_pkg::SEQ_WAIT:
          if (meas_done_i)
            state_reg <= pending_reg == 12'h000 ?
              limit_seq_pkg::SEQ_IDLE : limit_seq_pkg::SEQ_ISSUE;
        default:
          state_reg <= limit_seq_pkg::SEQ_IDLE;
      endcase
    end
  end

  logic busy_reg;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      busy_reg <= 1'b0;
    else
      busy_reg <= (start_ok && chosen_mask != 12'h000) ||
        (busy_reg && !last_done);
  end

  assign meas_req_o = meas_req_reg;
  assign meas_select_o = meas_select_reg;
  assign seq_busy_o = busy_reg;
  assign seq_done_o = done_reg;

  // ===================================================================
  // checks
  write_readback_a: assert property ( // R20
    wr_hit ##1 (rd_en_i && !wr_en_i && rd_addr_i == {1'b0, $past(wr_addr_i)})
    |=> rd_data_o == $past(wr_data_i, 2))
    else $error("read after write did not return the written word");

  battery_upper_a: assert property ( // R1
    wr_en_i && wr_addr_i == `LSD_WA_BATTERY_TWO_UPPER ##1
    (rd_en_i && !wr_en_i && rd_addr_i == `LSD_RA_BATTERY_TWO_UPPER)
    |=> rd_data_o == $past(wr_data_i, 2))
    else $error("battery-two upper limit readback wrong");

  unmapped_read_a: assert property ( // R20
    rd_en_i && !rd_hit |=> rd_data_o == 12'h000)
    else $error("read outside the bank returned nonzero");

  converter_fields_a: assert property ( // R14
    wr_en_i && wr_addr_i == `LSD_WA_OUTPUT_CONTROL |=>
    output_code_o == $past(wr_data_i[11:4]) &&
    full_span_o == $past(wr_data_i[0]) && // R15
    current_mode_o == $past(wr_data_i[2])) // R16
    else $error("converter control fields do not follow the write");

  power_off_hold_a: assert property ( // R17
    wr_en_i && wr_addr_i == `LSD_WA_OUTPUT_CONTROL && wr_data_i[3]
    ##1 !(wr_en_i && wr_addr_i == `LSD_WA_OUTPUT_CONTROL)[*2]
    |-> converter_power_off_o)
    else $error("converter not held powered off");

  battery_low_flag_a: assert property ( // R18
    result_valid_i && result_select_i == 4'h4 &&
    result_data_i < bat_lower |=> battery_two_low_flag_o)
    else $error("battery-two low flag not set");

  temp_alert_gate_a: assert property ( // R19
    !temperature_alert_enable_i && !battery_alert_enable_i
    |=> !alert_o)
    else $error("alert raised while its sources are disabled");

  temp_alert_route_a: assert property ( // R19
    temperature_alert_enable_i && temperature_high_flag_o |=> alert_o)
    else $error("enabled temperature alert did not reach the output");

  empty_mask_a: assert property ( // R21
    start_ok && chosen_mask == 12'h000 |=> seq_done_o && !meas_req_o
    ##1 !meas_req_o[*3])
    else $error("empty mask started a measurement");

  // a done with work left brings the next request two cycles later
  seq_order_a: assert property ( // R21
    meas_done_i && state_reg == limit_seq_pkg::SEQ_WAIT &&
    pending_reg != 12'h000 |-> ##2 meas_req_o &&
    meas_select_o > $past(meas_select_o, 2))
    else $error("sequence left ascending order");
endmodule

//--- hdl/limit_seq_defines.svh
// constants for the limit, sequence-mask and output converter register bank
// assumes inclusion by bare name; definitions only
`ifndef LIMIT_SEQ_DEFINES_SVH
`define LIMIT_SEQ_DEFINES_SVH

// =====================================================================
// bank shape
`define LSD_NUM_WORDS 7
`define LSD_WORD_BITS 12

// =====================================================================
// write addresses (4 bit) and read addresses (5 bit)
`define LSD_WA_BATTERY_TWO_UPPER 4'h8
`define LSD_WA_BATTERY_TWO_LOWER 4'h9
`define LSD_WA_TEMPERATURE_LOWER 4'hA
`define LSD_WA_TEMPERATURE_UPPER 4'hB
`define LSD_WA_SLAVE_MASK 4'hC
`define LSD_WA_MASTER_MASK 4'hD
`define LSD_WA_OUTPUT_CONTROL 4'hE
`define LSD_RA_BATTERY_TWO_UPPER 5'h08
`define LSD_RA_BATTERY_TWO_LOWER 5'h09
`define LSD_RA_TEMPERATURE_LOWER 5'h0A
`define LSD_RA_TEMPERATURE_UPPER 5'h0B
`define LSD_RA_SLAVE_MASK 5'h0C
`define LSD_RA_MASTER_MASK 5'h0D
`define LSD_RA_OUTPUT_CONTROL 5'h0E

// =====================================================================
// word index inside the bank, the low three address bits
`define LSD_IDX_BATTERY_TWO_UPPER 3'h0
`define LSD_IDX_BATTERY_TWO_LOWER 3'h1
`define LSD_IDX_TEMPERATURE_LOWER 3'h2
`define LSD_IDX_TEMPERATURE_UPPER 3'h3
`define LSD_IDX_SLAVE_MASK 3'h4
`define LSD_IDX_MASTER_MASK 3'h5
`define LSD_IDX_OUTPUT_CONTROL 3'h6

// =====================================================================
// reset values
`define LSD_RST_LIMIT 12'h000
`define LSD_RST_MASK 12'h000
`define LSD_RST_OUTPUT_CONTROL 12'h008

// =====================================================================
// sequence mask bit positions, same for slave and master masks
`define LSD_SEL_UNUSED 0
`define LSD_SEL_PRESSURE_ONE 1
`define LSD_SEL_DIFF_TEMP 2
`define LSD_SEL_SINGLE_TEMP 3
`define LSD_SEL_BATTERY_TWO 4
`define LSD_SEL_BATTERY_ONE 5
`define LSD_SEL_AUX_THREE 6
`define LSD_SEL_AUX_TWO 7
`define LSD_SEL_AUX_ONE 8
`define LSD_SEL_PRESSURE_TWO 9
`define LSD_SEL_HORIZONTAL 10
`define LSD_SEL_VERTICAL 11

// =====================================================================
// output converter control word fields
`define LSD_CTL_FULL_SPAN 0
`define LSD_CTL_UNUSED 1
`define LSD_CTL_CURRENT_MODE 2
`define LSD_CTL_POWER_OFF 3
`define LSD_CTL_CODE_LSB 4
`define LSD_CTL_CODE_MSB 11

`endif

//--- hdl/limit_seq_pkg.sv
// types shared by the register bank, its storage and the carrier interface
// assumes limit_seq_defines.svh is on the include path
`include "limit_seq_defines.svh"

package limit_seq_pkg;
  typedef logic [`LSD_WORD_BITS-1:0] word_t;
  typedef logic [2:0] index_t;
  typedef logic [3:0] select_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} seq_state_e;
endpackage

//--- hdl/reg_store_if.sv
// carrier between the bank control logic and its word storage
// assumes one clock shared by both ends
`timescale 1ns/1ps
`include "limit_seq_defines.svh"

interface reg_store_if;
  logic wr_en;
  limit_seq_pkg::index_t wr_idx;
  limit_seq_pkg::word_t wr_data;
  logic rd_en;
  logic rd_hit;
  limit_seq_pkg::index_t rd_idx;
  limit_seq_pkg::word_t rd_data;
  limit_seq_pkg::word_t words [`LSD_NUM_WORDS];
  modport store (input wr_en, wr_idx, wr_data, rd_en, rd_hit, rd_idx,
    output rd_data, words);
  modport user (output wr_en, wr_idx, wr_data, rd_en, rd_hit, rd_idx,
    input rd_data, words);
endinterface

//--- hdl/reg_store.sv
// word storage of the bank: one write port, one registered read port,
// and every word visible at once for the comparators and sequencer
// assumes synchronous active-low reset and a single clock
`timescale 1ns/1ps
`include "limit_seq_defines.svh"

module reg_store #(
  parameter int DEPTH = `LSD_NUM_WORDS,
  parameter logic [`LSD_NUM_WORDS*`LSD_WORD_BITS-1:0] RESET_IMAGE = '0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  reg_store_if.store bus
);
  if (DEPTH != `LSD_NUM_WORDS)
  begin : g_bad_depth
    $error("reg_store depth must match the bank size");
  end

  // ===================================================================
  // one flop word per register, each with its own reset value
  for (genvar w = 0; w < DEPTH; w++)
  begin : g_word
    always_ff @(posedge clock_i)
    begin
      if (!rst_n_i)
        bus.words[w] <= RESET_IMAGE[w*`LSD_WORD_BITS +: `LSD_WORD_BITS];
      else if (bus.wr_en && bus.wr_idx == 3'(w))
        bus.words[w] <= bus.wr_data;
    end
  end

  // ===================================================================
  // registered read; an address outside the bank answers zero
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      bus.rd_data <= '0;
    else if (bus.rd_en)
      bus.rd_data <= bus.rd_hit ? bus.words[bus.rd_idx] : '0;
  end
endmodule

//--- tb/conv_engine_model.sv
// behavioural converter engine that answers measurement requests
// assumes one request at a time and the bank's clock and reset
`timescale 1ns/1ps

module conv_engine_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic meas_req_i,
  input wire logic [3:0] meas_select_i,
  input wire logic slow_i,
  output logic meas_done_o
);
  // ==================================================================
  // answer timing
  logic busy_reg;
  logic [3:0] wait_reg;

  // one done per request; slow mode stalls by the channel number so
  // latency varies and ordering slips show up
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      busy_reg <= 1'b0;
      wait_reg <= 4'h0;
      meas_done_o <= 1'b0;
    end
    else
    begin
      meas_done_o <= 1'b0;
      if (meas_req_i)
      begin
        busy_reg <= 1'b1;
        wait_reg <= slow_i ? meas_select_i : 4'h0;
      end
      else if (busy_reg && wait_reg == 4'h0)
      begin
        meas_done_o <= 1'b1;
        busy_reg <= 1'b0;
      end
      else if (busy_reg)
        wait_reg <= wait_reg - 4'h1;
    end
  end
endmodule

//--- tb/limit_seq_bank_tb.sv
// self-checking bench for the limit, mask and converter control bank
// assumes conv_engine_model answers the sequencer's requests
`timescale 1ns/1ps

module limit_seq_bank_tb;
  logic clock_i, rst_n_i, wr_en, rd_en, rd_valid, seq_start, seq_master;
  logic meas_done, meas_req, seq_busy, seq_done, res_valid, a_clr;
  logic bat_en, tmp_en, bl, bh, tl, th, alert, span, cur, pdn, slow;
  logic [3:0] wr_addr, meas_sel, res_sel;
  logic [4:0] rd_addr;
  logic [11:0] wr_data, rd_data, res_data;
  logic [7:0] code;
  logic [11:0] rd_q[$];
  logic [3:0] sel_q[$];
  logic [11:0] data[7];
  logic [11:0] ctl[4] = '{12'hFF0, 12'h00F, 12'h5A5, 12'hA0A};
  logic [3:0] lsel[7] = '{4'h4, 4'h4, 4'h4, 4'h4, 4'h2, 4'h3, 4'h3};
  logic [11:0] ldat[7] = '{12'h0FF, 12'h100, 12'h801, 12'h800, 12'h000,
    12'h1FF, 12'h601};
  logic [4:0] lexp[7] = '{5'h11, 5'h00, 5'h09, 5'h00, 5'h00, 5'h04, 5'h02};
  int failures, num_checks, cycles, rnd;
  wire [11:0] pins = {code, pdn, cur, 1'b0, span};
  wire [11:0] flags = {7'h00, bl, bh, tl, th, alert};

  limit_seq_bank u_limit_seq_bank (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .seq_start_i(seq_start),
    .seq_master_i(seq_master), .meas_done_i(meas_done),
    .meas_req_o(meas_req), .meas_select_o(meas_sel), .seq_busy_o(seq_busy),
    .seq_done_o(seq_done), .result_valid_i(res_valid),
    .result_select_i(res_sel), .result_data_i(res_data),
    .alert_clear_i(a_clr), .battery_alert_enable_i(bat_en),
    .temperature_alert_enable_i(tmp_en), .battery_two_low_flag_o(bl),
    .battery_two_high_flag_o(bh), .temperature_low_flag_o(tl),
    .temperature_high_flag_o(th), .alert_o(alert), .output_code_o(code),
    .full_span_o(span), .current_mode_o(cur),
    .converter_power_off_o(pdn));

  conv_engine_model u_conv_engine_model (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .meas_req_i(meas_req), .meas_select_i(meas_sel),
    .slow_i(slow), .meas_done_o(meas_done));

  // ==================================================================
  // clock, timeout and result watcher
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      wrap_up();
    end
  end

  // sampled before the edge's updates land, so results are settled
  always @(posedge clock_i)
  begin
    if (rst_n_i === 1'b1 && rd_valid === 1'b1)
      chk(rd_data, rd_q.pop_front());
    if (rst_n_i === 1'b1 && meas_req === 1'b1)
      chk({8'h00, meas_sel}, {8'h00, sel_q.pop_front()});
  end

  // ==================================================================
  // tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge clock_i);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clock_i);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [11:0] e);
    rd_q.push_back(e);
    @(posedge clock_i);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clock_i);
    rd_en <= 1'b0;
  endtask

  // write then read the same word on the very next edge
  task automatic wr_rd(input logic [3:0] a, input logic [11:0] d);
    rd_q.push_back(d);
    @(posedge clock_i);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clock_i);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    rd_addr <= {1'b0, a};
    @(posedge clock_i);
    rd_en <= 1'b0;
  endtask

  task automatic run_seq(input logic m, input logic [11:0] k);
    int n;
    wr(m ? 4'hD : 4'hC, k);
    for (n = 1; n < 12; n++)
      if (k[n])
        sel_q.push_back(4'(n));
    @(posedge clock_i);
    seq_start <= 1'b1;
    seq_master <= m;
    @(posedge clock_i);
    seq_start <= 1'b0;
    #1;
    n = 0;
    while (seq_done !== 1'b1 && n < 400)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk({3'h0, 8'(sel_q.size()), seq_busy}, 12'h000);
  endtask

  task automatic result(input logic [3:0] s, input logic [11:0] d);
    @(posedge clock_i);
    a_clr <= 1'b1;
    @(posedge clock_i);
    a_clr <= 1'b0;
    res_valid <= 1'b1;
    res_sel <= s;
    res_data <= d;
    @(posedge clock_i);
    res_valid <= 1'b0;
    @(posedge clock_i);
    #1;
  endtask

  // ==================================================================
  // main sequence
  initial
  begin
    {rst_n_i, wr_en, rd_en, seq_start, seq_master, res_valid} = '0;
    {a_clr, tmp_en, slow, wr_addr, rd_addr, res_sel} = '0;
    {wr_data, res_data} = '0;
    bat_en = 1'b1;
    rnd = $urandom(32'h41a9);
    do_reset();
    for (int i = 0; i < 7; i++)
      rd(5'h08 + 5'(i), i == 6 ? 12'h008 : 12'h000);
    chk(pins, 12'h008);
    for (int i = 0; i < 7; i++)
    begin
      data[i] = 12'($urandom);
      wr(4'h8 + 4'(i), data[i]);
    end
    // unmapped writes must leave every word alone
    wr(4'h7, ~data[0]);
    wr(4'hF, ~data[1]);
    for (int i = 0; i < 7; i++)
      rd(5'h08 + 5'(i), data[i]);
    rd(5'h07, 12'h000);
    rd(5'h0F, 12'h000);
    wr_rd(4'h8, 12'($urandom));
    wr_rd(4'hD, 12'($urandom));
    for (int k = 0; k < 4; k++)
    begin
      wr(4'hE, ctl[k]);
      repeat (2) @(posedge clock_i);
      #1;
      chk(pins, ctl[k] & 12'hFFD);
      rd(5'h0E, ctl[k]);
    end
    run_seq(1'b0, 12'h819);
    run_seq(1'b1, 12'hFFF);
    @(posedge clock_i);
    slow <= 1'b1;
    run_seq(1'b0, 12'($urandom));
    run_seq(1'b1, 12'h000);
    run_seq(1'b1, 12'h3E6);
    wr(4'h9, 12'h100);
    wr(4'h8, 12'h800);
    wr(4'hA, 12'h200);
    wr(4'hB, 12'h600);
    for (int k = 0; k < 7; k++)
    begin
      result(lsel[k], ldat[k]);
      chk(flags, {7'h00, lexp[k]});
    end
    @(posedge clock_i);
    tmp_en <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    chk(flags, 12'h003);
    @(posedge clock_i);
    tmp_en <= 1'b0;
    bat_en <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    chk(flags, 12'h002);
    do_reset();
    rd(5'h0E, 12'h008);
    rd(5'h0D, 12'h000);
    chk(pins, 12'h008);
    repeat (3) @(posedge clock_i);
    chk(12'(rd_q.size()), 12'h000);
    wrap_up();
  end
endmodule
